// file: bench/simd_pick_and_precision_expand_tb.sv
// Purpose: Self-checking bench for the pick and expand slice
// Assumes: One-cycle writeback, zero-wait APB
// Notes:   Table rows first, then status, irq and reset cases
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module simd_pick_and_precision_expand_tb;
   import spx_pkg::*;
   typedef struct {logic [4:0] sa; logic [5:0] fn; logic [7:0] cc; spx_dword_t x;} spx_row_t;
   localparam spx_dword_t A = 64'h8899_AABB_CCDD_EEFF;
   localparam spx_dword_t B = 64'h89AB_CDEF_0123_4567;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, issue_valid, wb_valid, exc_reserved, exc_disabled, irq;
   logic [31:0] insn_word;
   logic [7:0] condition_bits;
   logic [4:0] wb_dest;
   spx_dword_t first_source, second_source, wb_data;
   int error_cnt = 0, n_tests = 0;
   spx_row_t rows [11] = '{
      '{5'h03, 6'h11, 8'h5A, 64'hFFFF_FFFF_CC23_EE67}, '{5'h03, 6'h11, 8'hA5, 64'h0000_0000_01DD_45FF},
      '{5'h0B, 6'h15, 8'h5A, 64'h8899_CDEF_CCDD_4567}, '{5'h0B, 6'h15, 8'hA5, 64'h89AB_AABB_0123_EEFF},
      '{5'h14, 6'h16, 8'h00, 64'h89AB_CDEF_0000_0000}, '{5'h15, 6'h16, 8'hFF, 64'h0123_4567_0000_0000},
      '{5'h0C, 6'h16, 8'h00, 64'h89AB_0000_CDEF_0000}, '{5'h0D, 6'h16, 8'h00, 64'h0123_0000_4567_0000},
      '{5'h0E, 6'h16, 8'h00, 64'h89AB_0000_0123_0000}, '{5'h0F, 6'h16, 8'h00, 64'hCDEF_0000_4567_0000},
      '{5'h0B, 6'h15, 8'hF0, 64'h89AB_CDEF_0123_4567}};
   always #12.5 pclk = ~pclk;
   spx_host_model i_host (.pclk(pclk), .issue_valid(issue_valid), .insn_word(insn_word),
      .first_source(first_source), .second_source(second_source),
      .condition_bits(condition_bits));
   spx_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .issue_valid(issue_valid), .insn_word(insn_word),
      .first_source(first_source), .second_source(second_source),
      .condition_bits(condition_bits), .wb_valid(wb_valid), .wb_data(wb_data),
      .wb_dest(wb_dest), .exc_reserved(exc_reserved), .exc_disabled(exc_disabled), .irq(irq));
   function automatic logic [31:0] enc(logic [4:0] r, d, s, logic [5:0] f);
      return {6'h1F, r, 5'h00, d, s, f};
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         error_cnt++;
         tally_and_finish();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic op(input logic [31:0] i, input logic [7:0] c);
      i_host.issue(i, A, B, c);
      #1;
   endtask
   initial begin
      repeat (5000) @(posedge pclk);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         op(enc(5'h00, 5'(i + 1), rows[i].sa, rows[i].fn), rows[i].cc);
         `CHK({wb_valid, wb_dest, wb_data}, {1'b1, 5'(i + 1), rows[i].x})
         `CHK({exc_reserved, exc_disabled}, 2'b00)
      end
      $display("table done");
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd, 32'h0000_0004)
      apb(1'b0, 12'h010, 32'h0);
      `CHK(rd, 32'h0000_000B)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK(rd, 32'h7C00_5AD5)
      op(enc(5'h01, 5'h03, 5'h15, 6'h16), 8'h00);
      `CHK({exc_reserved, exc_disabled, wb_valid, wb_data}, {3'b100, rows[10].x})
      op(enc(5'h00, 5'h03, 5'h1F, 6'h16), 8'h00);
      `CHK({exc_reserved, wb_valid}, 2'b10)
      op(32'h0000_0000, 8'h00);
      `CHK({exc_reserved, exc_disabled, wb_valid}, 3'b100)
      apb(1'b1, 12'h008, 32'h2);
      `CHK(irq, 1'b0)
      apb(1'b1, 12'h000, 32'h0);
      op(enc(5'h00, 5'h04, 5'h03, 6'h11), 8'h0F);
      `CHK({exc_reserved, exc_disabled, wb_valid}, 3'b010)
      `CHK(irq, 1'b1)
      apb(1'b1, 12'h004, 32'h7);
      `CHK(irq, 1'b0)
      // Event and clear on one edge: set wins
      fork
         apb(1'b1, 12'h004, 32'h7);
         begin
            @(posedge pclk);
            op(enc(5'h00, 5'h05, 5'h03, 6'h11), 8'h00);
         end
      join
      apb(1'b0, 12'h004, 32'h0);
      `CHK({rd, irq}, {32'h0000_0002, 1'b1})
      apb(1'b0, 12'h100, 32'h0);
      `CHK({rd, pready, pslverr}, {32'h0, 2'b10})
      $display("status test done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      `CHK({rd, irq, wb_valid, wb_data}, {32'h1, 1'b0, 1'b0, 64'h0})
      apb(1'b0, 12'h008, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rd, 32'h0)
      op(enc(5'h00, 5'h06, 5'h14, 6'h16), 8'h00);
      `CHK({wb_valid, wb_dest, wb_data}, {1'b1, 5'h06, rows[4].x})
      $display("reset test done");
      tally_and_finish();
   end
endmodule

// file: bench/spx_host_model.sv
// Purpose: Host pipeline stand-in that issues one instruction
// Assumes: Bench calls issue() from its main sequence
// Notes:   Released operand lines show inverted data
`timescale 1ns/100ps
module spx_host_model (
   // Clock
   input  wire logic           pclk,
   // Issue side
   output logic                issue_valid,
   output logic [31:0]         insn_word,
   output spx_pkg::spx_dword_t first_source,
   output spx_pkg::spx_dword_t second_source,
   output logic [7:0]          condition_bits
);
   import spx_pkg::*;
   initial begin
      issue_valid = 1'b0;
      insn_word = 32'h0;
      first_source = 64'h0;
      second_source = 64'h0;
      condition_bits = 8'h0;
   end
   task automatic issue(input logic [31:0] i, input spx_dword_t a, b, input logic [7:0] c);
      @(posedge pclk);
      issue_valid <= 1'b1;
      insn_word <= i;
      first_source <= a;
      second_source <= b;
      condition_bits <= c;
      @(posedge pclk);
      issue_valid <= 1'b0;
      insn_word <= ~i;
      first_source <= ~a;
      second_source <= ~b;
      condition_bits <= ~c;
   endtask
endmodule

// file: hw/spx_core.sv
// Purpose: SIMD pick and precision-expand datapath with APB status
// Assumes: Operands and condition bits valid with issue_valid
// Notes:   Result, destination write and exceptions registered one cycle
//
// Functional notes
// - Decode quad byte pick encoding
// - Byte pick by condition bits, sign extended
// - Decode quad halfword pick encoding
// - Condition bits steer four halfwords
// - Halfword pick fills 64 bits unextended
// - Left word expand, low half cleared
// - Right word moved up, low half cleared
// - Left halfword pair expanded to words
// - Right halfword pair expanded to words
// - Left alternate halfwords expanded to words
// - Right alternate halfwords expanded to words
// - No operand-dependent exceptions
// - Only reserved and disabled exceptions
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "spx_defs.svh"

module spx_core (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Issue from pipeline
   input  wire logic               issue_valid,
   input  wire logic [31:0]        insn_word,
   input  wire spx_pkg::spx_dword_t first_source,
   input  wire spx_pkg::spx_dword_t second_source,
   input  wire logic [7:0]         condition_bits,
   // Writeback
   output logic                    wb_valid,
   output spx_pkg::spx_dword_t     wb_data,
   output logic [4:0]              wb_dest,
   output logic                    exc_reserved,
   output logic                    exc_disabled,
   // Interrupt
   output logic                    irq
);
   import spx_pkg::*;

   // ****************************************************************
   // Decode
   // ****************************************************************
   function automatic spx_op_t spx_decode(input logic [31:0] w);
      spx_op_t op;
      op = SPX_OP_NONE;
      if (w[31:26] == `SPX_MAJOR_OPC) begin
         if (w[5:0] == `SPX_FN_QUAD_BYTE && w[10:6] == `SPX_SA_PICK_QUAD_BYTE)
            op = SPX_OP_PKQB;
         if (w[5:0] == `SPX_FN_OCTAL_BYTE && w[10:6] == `SPX_SA_PICK_QUAD_HALF)
            op = SPX_OP_PKQH;
         if (w[5:0] == `SPX_FN_QUAD_HALF && w[25:21] == 5'h00) begin
            case (w[10:6])
               `SPX_SA_EXP_LWD: op = SPX_OP_LWD;
               `SPX_SA_EXP_RWD: op = SPX_OP_RWD;
               `SPX_SA_EXP_LHP: op = SPX_OP_LHP;
               `SPX_SA_EXP_RHP: op = SPX_OP_RHP;
               `SPX_SA_EXP_LAH: op = SPX_OP_LAH;
               `SPX_SA_EXP_RAH: op = SPX_OP_RAH;
               default:         op = SPX_OP_NONE;
            endcase
         end
      end
      return op;
   endfunction

   // Halfword padded with 16 low zeros
   function automatic logic [31:0] spx_q15_to_q31(input logic [15:0] h);
      return {h, 16'h0000};
   endfunction

   spx_op_t          op_dec;
   logic [31:0]      ctrl_r;
   logic [`SPX_EV_W-1:0] stat_r;
   logic [`SPX_EV_W-1:0] mask_r;
   logic [31:0]      last_insn_r;
   logic [31:0]      op_cnt_r;
   logic             unit_en;
   logic [31:0]      pick_byte;
   spx_dword_t       pick_half;
   spx_dword_t       result;
   logic             ev_ri;
   logic             ev_dis;
   logic             ev_done;
   logic [`SPX_EV_W-1:0] ev_vec;
   logic             apb_wr;
   logic             apb_rd;

   assign op_dec  = spx_decode(insn_word);
   assign unit_en = ctrl_r[`SPX_CTRL_EN_BIT];

   // ****************************************************************
   // Pick datapath
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pick
         assign pick_byte[gi*8 +: 8] = condition_bits[gi] ?
            first_source[gi*8 +: 8] : second_source[gi*8 +: 8];
         assign pick_half[gi*16 +: 16] = condition_bits[gi] ?
            first_source[gi*16 +: 16] : second_source[gi*16 +: 16];
      end
   endgenerate

   // ****************************************************************
   // Result select
   // ****************************************************************
   // pure data moves, no value-dependent traps
   always_comb begin
      result = 64'h0000_0000_0000_0000;
      case (op_dec)
         SPX_OP_PKQB: result = {{32{pick_byte[31]}}, pick_byte};
         SPX_OP_PKQH: result = pick_half;
         SPX_OP_LWD:  result = {second_source[63:32], 32'h0000_0000};
         SPX_OP_RWD:  result = {second_source[31:0], 32'h0000_0000};
         SPX_OP_LHP:  result = {spx_q15_to_q31(second_source[63:48]),
                                spx_q15_to_q31(second_source[47:32])};
         SPX_OP_RHP:  result = {spx_q15_to_q31(second_source[31:16]),
                                spx_q15_to_q31(second_source[15:0])};
         SPX_OP_LAH:  result = {spx_q15_to_q31(second_source[63:48]),
                                spx_q15_to_q31(second_source[31:16])};
         SPX_OP_RAH:  result = {spx_q15_to_q31(second_source[47:32]),
                                spx_q15_to_q31(second_source[15:0])};
         default:     result = 64'h0000_0000_0000_0000;
      endcase
   end

   assign ev_ri   = issue_valid && unit_en && (op_dec == SPX_OP_NONE);
   assign ev_dis  = issue_valid && !unit_en;
   assign ev_done = issue_valid && unit_en && (op_dec != SPX_OP_NONE);
   always_comb begin
      ev_vec = '0;
      ev_vec[`SPX_EV_RI]   = ev_ri;
      ev_vec[`SPX_EV_DIS]  = ev_dis;
      ev_vec[`SPX_EV_DONE] = ev_done;
   end

   // ****************************************************************
   // Writeback registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wb_valid     <= 1'b0;
         wb_data      <= 64'h0000_0000_0000_0000;
         wb_dest      <= 5'h00;
         exc_reserved <= 1'b0;
         exc_disabled <= 1'b0;
      end else begin
         wb_valid     <= ev_done;
         exc_reserved <= ev_ri;
         exc_disabled <= ev_dis;
         if (ev_done) begin
            wb_data <= result;
            wb_dest <= insn_word[15:11];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_insn_r <= 32'h0000_0000;
         op_cnt_r    <= 32'h0000_0000;
      end else if (issue_valid) begin
         last_insn_r <= insn_word;
         if (ev_done)
            op_cnt_r <= op_cnt_r + 32'h0000_0001;
      end
   end

   // ****************************************************************
   // APB registers
   // ****************************************************************
   assign apb_wr  = psel && penable && pwrite;
   assign apb_rd  = psel && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_r <= `SPX_CTRL_RST;
      else if (apb_wr && paddr == `SPX_OFF_CTRL)
         ctrl_r <= pwdata;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         mask_r <= '0;
      else if (apb_wr && paddr == `SPX_OFF_MASK)
         mask_r <= pwdata[`SPX_EV_W-1:0];
   end

   // Set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         stat_r <= '0;
      else if (apb_wr && paddr == `SPX_OFF_STAT)
         stat_r <= (stat_r & ~pwdata[`SPX_EV_W-1:0]) | ev_vec;
      else
         stat_r <= stat_r | ev_vec;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (apb_rd && !penable) begin
         case (paddr)
            `SPX_OFF_CTRL: prdata <= ctrl_r;
            `SPX_OFF_STAT: prdata <= {{(32-`SPX_EV_W){1'b0}}, stat_r};
            `SPX_OFF_MASK: prdata <= {{(32-`SPX_EV_W){1'b0}}, mask_r};
            `SPX_OFF_INSN: prdata <= last_insn_r;
            `SPX_OFF_CNT:  prdata <= op_cnt_r;
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign irq = |(stat_r & mask_r);

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_PICK_QUAD_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQB) |=>
         wb_data[63:32] == {32{wb_data[31]}})
      else $error("byte pick upper half not sign copy");
   AST_DEC_QB: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[31:26] == 6'h1F &&
       insn_word[10:6] == 5'h03 && insn_word[5:0] == 6'h11) |=> wb_valid)
      else $error("byte pick not decoded");
   AST_DEC_QH: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[31:26] == 6'h1F &&
       insn_word[10:6] == 5'h0B && insn_word[5:0] == 6'h15) |=> wb_valid)
      else $error("halfword pick not decoded");
   AST_PICK_QUAD_HALF: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQH && condition_bits[3]) |=>
         wb_data[63:48] == $past(first_source[63:48]))
      else $error("halfword pick wrong source");
   AST_PICK_QUAD_HALF_ALL: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQH && condition_bits[3:0] == 4'h0) |=>
         wb_data == $past(second_source))
      else $error("halfword pick not full width");
   AST_LWD: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_LWD) |=>
         wb_data == {$past(second_source[63:32]), 32'h0000_0000})
      else $error("left word expand wrong");
   AST_RWD: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_RWD) |=>
         wb_data == {$past(second_source[31:0]), 32'h0000_0000})
      else $error("right word expand wrong");
   AST_HALF_PAD: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && (op_dec == SPX_OP_LHP || op_dec == SPX_OP_RHP ||
       op_dec == SPX_OP_LAH || op_dec == SPX_OP_RAH)) |=>
         (wb_data[15:0] == 16'h0000 && wb_data[47:32] == 16'h0000))
      else $error("halfword expand not zero padded");
   AST_EXC: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && !unit_en) |=> (exc_disabled && !wb_valid && !exc_reserved))
      else $error("disabled unit did not trap");
   AST_NO_DATA_EXC: assert property (@(posedge pclk) disable iff (!presetn)
      wb_valid |-> (!exc_reserved && !exc_disabled))
      else $error("exception beside a result");

   // ****************************************************************
   // Element and decode checks
   // ****************************************************************
   AST_PICK_QUAD_BYTE_BYTE0: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQB) |=>
         wb_data[7:0] == ($past(condition_bits[0]) ? $past(first_source[7:0]) :
                          $past(second_source[7:0])))
      else $error("byte pick lowest byte wrong");
   AST_PICK_QUAD_BYTE_BYTE3: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQB) |=>
         wb_data[31:24] == ($past(condition_bits[3]) ? $past(first_source[31:24]) :
                            $past(second_source[31:24])))
      else $error("byte pick top byte wrong");
   AST_PICK_QUAD_HALF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_PKQH) |=>
         wb_data[15:0] == ($past(condition_bits[0]) ? $past(first_source[15:0]) :
                           $past(second_source[15:0])))
      else $error("halfword pick lowest half wrong");
   AST_LHP: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_LHP) |=>
         wb_data == {$past(second_source[63:48]), 16'h0000,
                     $past(second_source[47:32]), 16'h0000})
      else $error("left halfword pair expand wrong");
   AST_RHP: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_RHP) |=>
         wb_data == {$past(second_source[31:16]), 16'h0000,
                     $past(second_source[15:0]), 16'h0000})
      else $error("right halfword pair expand wrong");
   AST_LAH: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_LAH) |=>
         wb_data == {$past(second_source[63:48]), 16'h0000,
                     $past(second_source[31:16]), 16'h0000})
      else $error("left alternate expand wrong");
   AST_RAH: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_done && op_dec == SPX_OP_RAH) |=>
         wb_data == {$past(second_source[47:32]), 16'h0000,
                     $past(second_source[15:0]), 16'h0000})
      else $error("right alternate expand wrong");
   AST_DEC_LWD: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[31:21] == 11'h3E0 &&
       insn_word[10:6] == 5'h14 && insn_word[5:0] == 6'h16) |=> wb_valid)
      else $error("left word expand not decoded");
   AST_DEC_RWD: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[31:21] == 11'h3E0 &&
       insn_word[10:6] == 5'h15 && insn_word[5:0] == 6'h16) |=> wb_valid)
      else $error("right word expand not decoded");
   AST_RI: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[31:26] != 6'h1F) |=>
         (exc_reserved && !wb_valid && !exc_disabled))
      else $error("foreign major opcode not trapped");
   AST_EXP_RS: assert property (@(posedge pclk) disable iff (!presetn)
      (issue_valid && unit_en && insn_word[5:0] == 6'h16 && insn_word[25:21] != 5'h00)
         |=> exc_reserved)
      else $error("expand with nonzero source field not trapped");
   AST_STAT_SET: assert property (@(posedge pclk) disable iff (!presetn)
      (ev_vec != '0) |=> ((stat_r & $past(ev_vec)) == $past(ev_vec)))
      else $error("status event lost");
endmodule

// file: hw/spx_defs.svh
// Purpose: Constants for the SIMD pick and precision-expand slice
// Assumes: Included by bare name
// Notes:   Encodings, register offsets and reset values
`ifndef SPX_DEFS_SVH
`define SPX_DEFS_SVH

// ****************************************************************
// Instruction encoding
// ****************************************************************
`define SPX_MAJOR_OPC        6'h1F
`define SPX_FN_QUAD_BYTE     6'h11
`define SPX_FN_OCTAL_BYTE    6'h15
`define SPX_FN_QUAD_HALF     6'h16
`define SPX_SA_PICK_QUAD_BYTE       5'h03
`define SPX_SA_PICK_QUAD_HALF       5'h0B
`define SPX_SA_EXP_LWD       5'h14
`define SPX_SA_EXP_RWD       5'h15
`define SPX_SA_EXP_LHP       5'h0C
`define SPX_SA_EXP_RHP       5'h0D
`define SPX_SA_EXP_LAH       5'h0E
`define SPX_SA_EXP_RAH       5'h0F
`define SPX_COND_LO          24
`define SPX_COND_W           4

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SPX_OFF_CTRL         12'h000
`define SPX_OFF_STAT         12'h004
`define SPX_OFF_MASK         12'h008
`define SPX_OFF_INSN         12'h00C
`define SPX_OFF_CNT          12'h010
`define SPX_CTRL_EN_BIT      0
`define SPX_CTRL_RST         32'h0000_0001
`define SPX_EV_RI            0
`define SPX_EV_DIS           1
`define SPX_EV_DONE          2
`define SPX_EV_W             3
`endif

// file: hw/spx_pkg.sv
// Purpose: Types for the SIMD pick and precision-expand slice
// Assumes: Nothing
// Notes:   Operation codes are one-hot
package spx_pkg;
   typedef enum logic [8:0] {
      SPX_OP_NONE   = 9'h001,
      SPX_OP_PKQB   = 9'h002,
      SPX_OP_PKQH   = 9'h004,
      SPX_OP_LWD    = 9'h008,
      SPX_OP_RWD    = 9'h010,
      SPX_OP_LHP    = 9'h020,
      SPX_OP_RHP    = 9'h040,
      SPX_OP_LAH    = 9'h080,
      SPX_OP_RAH    = 9'h100
   } spx_op_t;
   typedef logic [63:0] spx_dword_t;
endpackage
